// File: bench/pad_scan_model.sv
// Scan engine stand-in: issues scan pulses to the arithmetic unit.
// Assumes the unit samples scan_tick on the rising clock edge.
`timescale 1ns/1ns

module pad_scan_model (
    input  wire logic clk,
    output logic      scan_tick
);
    initial scan_tick = 1'b0;

    // Gap gives slow scans, n above 1 gives back-to-back scans
    task automatic pulse(input int gap, input int n);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        scan_tick <= 1'b1;
        repeat (n) @(posedge clk);
        scan_tick <= 1'b0;
    endtask
endmodule

// File: bench/pad_unit_sva.sv
// Port-level checks of the arithmetic unit.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ns
`include "pad_map.svh"

module pad_unit_chk #(
    parameter int DW = 16,
    parameter int AW = 4
) (
    input wire logic          clk,
    input wire logic          sys_rst,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic          wr_stb,
    input wire logic          rd_stb,
    input wire logic          scan_tick,
    input wire logic [DW-1:0] rd_data,
    input wire logic          zero_result_flag,
    input wire logic          borrow_out_flag,
    input wire logic          carry_out_flag,
    input wire logic          exec_error_flag,
    input wire logic          exec_error_latched_flag
);
    logic clr_err;
    logic clr_lat;

    assign clr_err = wr_stb && addr == `PAD_A_FLAGS && wr_data[`PAD_FL_ERR];
    assign clr_lat = wr_stb && addr == `PAD_A_FLAGS && wr_data[`PAD_FL_LATCH];

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    err_from_scan_a: assert property (
        $rose(exec_error_flag) |-> $past(scan_tick)) else $error("error flag rose without scan");
    err_pair_a: assert property (
        $rose(exec_error_flag) |-> exec_error_latched_flag) else $error("latched flag not set");
    latch_hold_a: assert property (
        exec_error_latched_flag && !clr_lat |=> exec_error_latched_flag)
        else $error("latched flag dropped");
    err_hold_a: assert property (
        exec_error_flag && !clr_err |=> exec_error_flag) else $error("error flag dropped");
    // Result flags (zero, borrow, carry) may only move after a scan or a reset
    flags_idle_a: assert property (
        !$past(scan_tick) && !$past(sys_rst)
        |-> $stable({zero_result_flag, borrow_out_flag, carry_out_flag}))
        else $error("result flags moved without scan");
    one_ovf_a: assert property (
        !(borrow_out_flag && carry_out_flag)) else $error("borrow and carry both set");
    // Positive overflow can never wrap to exactly zero
    carry_zero_a: assert property (
        !(carry_out_flag && zero_result_flag)) else $error("carry with zero result");
    rd_idle_a: assert property (
        !$past(rd_stb) |-> rd_data == {DW{1'b0}}) else $error("read data outside read slot");
endmodule

bind pad_unit pad_unit_chk #(.DW(DW), .AW(AW)) chk (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .scan_tick(scan_tick), .rd_data(rd_data),
    .zero_result_flag(zero_result_flag), .borrow_out_flag(borrow_out_flag),
    .carry_out_flag(carry_out_flag), .exec_error_flag(exec_error_flag),
    .exec_error_latched_flag(exec_error_latched_flag));

// File: bench/testbench.sv
// Self-checking bench of the arithmetic unit.
// Assumes the unit, the scan engine model and the checker are compiled first.
`timescale 1ns/1ns
`include "pad_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %h got %h", nm, e, g); end end

module testbench;
    logic        clk;
    logic        sys_rst;
    logic [3:0]  addr;
    logic [15:0] wr_data;
    logic        wr_stb;
    logic        rd_stb;
    logic        scan_tick;
    logic [15:0] rd_data;
    logic        zf;
    logic        bf;
    logic        cf;
    logic        ef;
    logic        lf;
    int          err_total;
    int          n_checks;

    pad_unit dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .scan_tick(scan_tick), .rd_data(rd_data),
        .zero_result_flag(zf), .borrow_out_flag(bf), .carry_out_flag(cf),
        .exec_error_flag(ef), .exec_error_latched_flag(lf));
    pad_scan_model eng (.clk(clk), .scan_tick(scan_tick));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        d = rd_data;
    endtask

    task automatic rchk(input string nm, input logic [3:0] a, input logic [15:0] e);
        logic [15:0] v;
        rd(a, v);
        `CHK(nm, e, v)
    endtask

    task automatic do_reset;
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    task automatic run(input logic [15:0] c, input logic [31:0] a, input logic [31:0] b);
        wr(`PAD_A_SRC1_LO, a[15:0]);
        wr(`PAD_A_SRC1_HI, a[31:16]);
        wr(`PAD_A_SRC2_LO, b[15:0]);
        wr(`PAD_A_SRC2_HI, b[31:16]);
        wr(`PAD_A_CTRL, c);
        wr(`PAD_A_COND, 16'h0001);
        eng.pulse(0, 1);
        @(negedge clk);
    endtask

    // Expected value from sign-extended true result
    task automatic arith(input logic [1:0] op, input logic w, input logic [31:0] a,
                         input logic [31:0] b);
        logic signed [33:0] sa;
        logic signed [33:0] sb;
        logic signed [33:0] t;
        logic [31:0]        r;
        sa = w ? {{2{a[31]}}, a} : {{18{a[15]}}, a[15:0]};
        sb = w ? {{2{b[31]}}, b} : {{18{b[15]}}, b[15:0]};
        t = (op == 2'h1) ? sa + sb : sa - sb;
        r = w ? t[31:0] : {16'h0000, t[15:0]};
        run({13'h0000, w, op}, a, b);
        `CHK("zero", r == 32'h0, zf)
        `CHK("borrow", w ? t < -34'sh80000000 : t < -34'sh8000, bf)
        `CHK("carry", w ? t > 34'sh7FFFFFFF : t > 34'sh7FFF, cf)
        rchk("res lo", `PAD_A_RES0, r[15:0]);
        if (w) begin
            rchk("res hi", `PAD_A_RES1, r[31:16]);
        end
    endtask

    task automatic refuse(input logic [15:0] c);
        logic [15:0] r0;
        logic [15:0] st;
        wr(`PAD_A_STATUS, 16'h0001);
        rd(`PAD_A_RES0, r0);
        run(c, 32'h0002_0002, 32'h0003_0003);
        rd(`PAD_A_STATUS, st);
        `CHK("refused", 1'b1, st[`PAD_ST_ILLEGAL])
        rchk("res kept", `PAD_A_RES0, r0);
    endtask

    task automatic t_conv;
        run(16'h0000, 32'h0000_1234, 32'h0);
        rchk("bin", `PAD_A_RES0, 16'h04D2);
        run(16'h0000, 32'h0000_9999, 32'h0);
        rchk("max16", `PAD_A_RES0, 16'h270F);
        run(16'h0004, 32'h9999_9999, 32'h0);
        rchk("max32 lo", `PAD_A_RES0, 16'hE0FF);
        rchk("max32 hi", `PAD_A_RES1, 16'h05F5);
        run(16'h0000, 32'h0000_00A1, 32'h0);
        `CHK("err", 1'b1, ef)
        `CHK("latched", 1'b1, lf)
        rchk("code", `PAD_A_ERRCODE, `PAD_ERR_BCD);
        rchk("res on err", `PAD_A_RES0, 16'hE0FF);
        run(16'h0000, 32'h0000_0042, 32'h0);
        `CHK("latched kept", 1'b1, lf)
        wr(`PAD_A_FLAGS, 16'h0008);
        @(negedge clk);
        `CHK("err after clr", 1'b0, ef)
        `CHK("latched after clr", 1'b1, lf)
        wr(`PAD_A_FLAGS, 16'h0010);
        @(negedge clk);
        `CHK("latched sw clr", 1'b0, lf)
        run(16'h0000, 32'h0000_00A1, 32'h0);
        `CHK("latched again", 1'b1, lf)
        do_reset;
        @(negedge clk);
        `CHK("latched reset", 1'b0, lf)
        `CHK("err reset", 1'b0, ef)
    endtask

    task automatic t_arith;
        arith(2'h1, 1'b0, 32'h0003, 32'hFFF7);
        arith(2'h1, 1'b0, 32'h7FFF, 32'h0001);
        arith(2'h1, 1'b0, 32'h8000, 32'hFFFF);
        arith(2'h1, 1'b0, 32'h8000, 32'h8000);
        arith(2'h1, 1'b1, 32'h7FFF_FFFF, 32'h0000_0001);
        arith(2'h1, 1'b1, 32'h8000_0000, 32'hFFFF_FFFF);
        arith(2'h1, 1'b1, 32'h0001_0000, 32'hFFFF_0000);
        arith(2'h2, 1'b0, 32'h0005, 32'h0007);
        arith(2'h2, 1'b0, 32'h8000, 32'h0001);
        arith(2'h2, 1'b0, 32'h7FFF, 32'hFFFF);
        arith(2'h2, 1'b1, 32'h8000_0000, 32'h0000_0001);
        arith(2'h2, 1'b1, 32'h0001_0000, 32'h0000_0001);
    endtask

    task automatic t_prod;
        logic [15:0] st;
        run(16'h0003, 32'h0000_FFFD, 32'h0000_03E8);
        rchk("p16 lo", `PAD_A_RES0, 16'hF448);
        rchk("p16 hi", `PAD_A_RES1, 16'hFFFF);
        run(16'h0007, 32'h8000_0000, 32'h0000_0002);
        rchk("p32 w1", `PAD_A_RES1, 16'h0000);
        rchk("p32 w3", `PAD_A_RES3, 16'hFFFF);
        run(16'h00C3, 32'h0000_0012, 32'h0000_0003);
        rchk("k1 lo", `PAD_A_RES0, 16'h0006);
        run(16'h0447, 32'h0001_2345, 32'h0000_0010);
        rchk("k8 w1", `PAD_A_RES1, 16'h0012);
        rchk("k8 w3", `PAD_A_RES3, 16'h0000);
        refuse(16'h0014);
        refuse(16'h0015);
        refuse(16'h0027);
        refuse(16'h02C3);
        refuse(16'h0043);
        refuse(16'h04C7);
        wr(`PAD_A_STATUS, 16'h0001);
        run(16'h0011, 32'h0000_0002, 32'h0000_0003);
        rchk("narrow idx", `PAD_A_RES0, 16'h0005);
        rd(`PAD_A_STATUS, st);
        `CHK("not refused", 1'b0, st[`PAD_ST_ILLEGAL])
        run(16'h0025, 32'h0001_0000, 32'h0000_0002);
        rchk("idx e sum", `PAD_A_RES1, 16'h0001);
    endtask

    task automatic t_pulse;
        logic [15:0] s0;
        logic [15:0] s1;
        run(16'h0009, 32'h0000_0001, 32'h0000_0001);
        wr(`PAD_A_COND, 16'h0000);
        eng.pulse(3, 1);
        rd(`PAD_A_STATUS, s0);
        wr(`PAD_A_COND, 16'h0001);
        eng.pulse(0, 3);
        rd(`PAD_A_STATUS, s1);
        `CHK("pulse count", s0[15:8] + 8'h01, s1[15:8])
        wr(`PAD_A_CTRL, 16'h0001);
        eng.pulse(2, 3);
        rd(`PAD_A_STATUS, s0);
        `CHK("cont count", s1[15:8] + 8'h03, s0[15:8])
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Guard against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish;
    end

    initial begin
        sys_rst = 1'b1;
        addr = 4'h0;
        wr_data = 16'h0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        err_total = 0;
        n_checks = 0;
        do_reset;
        t_conv;
        t_arith;
        t_prod;
        t_pulse;
        tally_and_finish;
    end
endmodule

// File: logic/pad_map.svh
// Register offsets, field positions, reset values and codes of the arithmetic unit.
// Assumes a 16-bit word bus with 4-bit word addresses.
`ifndef PAD_MAP_SVH
`define PAD_MAP_SVH

`define PAD_A_SRC1_LO   4'h0
`define PAD_A_SRC1_HI   4'h1
`define PAD_A_SRC2_LO   4'h2
`define PAD_A_SRC2_HI   4'h3
`define PAD_A_CTRL      4'h4
`define PAD_A_COND      4'h5
`define PAD_A_RES0      4'h6
`define PAD_A_RES1      4'h7
`define PAD_A_RES2      4'h8
`define PAD_A_RES3      4'h9
`define PAD_A_FLAGS     4'hA
`define PAD_A_ERRCODE   4'hB
`define PAD_A_STATUS    4'hC

`define PAD_CTRL_OP_LO  0
`define PAD_CTRL_OP_HI  1
`define PAD_CTRL_WIDE   2
`define PAD_CTRL_PULSE  3
`define PAD_CTRL_IDX_F  4
`define PAD_CTRL_IDX_E  5
`define PAD_CTRL_DBITS  6
`define PAD_CTRL_KN_LO  7
`define PAD_CTRL_KN_HI  10

`define PAD_FL_ZERO     0
`define PAD_FL_BORROW   1
`define PAD_FL_CARRY    2
`define PAD_FL_ERR      3
`define PAD_FL_LATCH    4

`define PAD_ST_ILLEGAL  0
`define PAD_ST_CNT_LO   8
`define PAD_ST_CNT_HI   15

`define PAD_ERR_BCD     16'h0E18
`define PAD_RST_WORD    16'h0000
`define PAD_KN_MAX16    4'h4
`define PAD_KN_MAX32    4'h8
`define PAD_KN_MIN      4'h1
`define PAD_DIGITS16    4
`define PAD_DIGITS32    8

`endif

// File: logic/pad_pkg.sv
// Types shared by the arithmetic unit and its register map.
// Assumes the constants of pad_map.svh.
package pad_pkg;

    typedef enum logic [1:0] {
        PAD_OP_CONV,
        PAD_OP_SUM,
        PAD_OP_DIFF,
        PAD_OP_PROD
    } pad_op_t;

    typedef struct packed {
        logic [3:0] kn;
        logic       dst_bits;
        logic       idx_e;
        logic       idx_f;
        logic       pulse;
        logic       wide;
        pad_op_t    op;
    } pad_ctrl_t;

    typedef struct packed {
        logic latched;
        logic err;
        logic carry;
        logic borrow;
        logic zero;
    } pad_flags_t;

endpackage

// File: logic/pad_unit.sv
// Arithmetic execution unit: decimal conversion, signed sum, difference, product.
// Assumes a scan engine on the same clock that loads operands over the word port
// and pulses scan_tick once per scan.
`timescale 1ns/1ns
`include "pad_map.svh"

module pad_unit #(
    parameter int DW = 16,
    parameter int AW = 4
) (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic          wr_stb,
    input  wire logic          rd_stb,
    input  wire logic          scan_tick,
    output logic      [DW-1:0] rd_data,
    output logic               zero_result_flag,
    output logic               borrow_out_flag,
    output logic               carry_out_flag,
    output logic               exec_error_flag,
    output logic               exec_error_latched_flag
);

    // Word slicing assumes 16-bit words and a 4-bit map
    if (DW != 16) begin : g_bad_dw
        $error("pad_unit: DW must be 16");
    end
    if (AW < 4) begin : g_bad_aw
        $error("pad_unit: AW must be at least 4");
    end

    logic [DW-1:0]       src1_lo_q;
    logic [DW-1:0]       src1_hi_q;
    logic [DW-1:0]       src2_lo_q;
    logic [DW-1:0]       src2_hi_q;
    pad_pkg::pad_ctrl_t  ctrl_q;
    logic                cond_q;
    logic                cond_prev_q;
    logic [DW-1:0]       res_q [4];
    logic [DW-1:0]       err_code_q;
    logic                illegal_q;
    logic [7:0]          exec_cnt_q;
    logic [DW-1:0]       rd_data_q;
    pad_pkg::pad_flags_t flags_q;

    logic                wr_flags;
    logic                clr_err;
    logic                clr_latch;
    logic                fire;
    logic                illegal;
    logic                run;
    logic                bcd_ok;
    logic [31:0]         src1_w;
    logic [31:0]         src2_w;
    logic [31:0]         conv_val;
    logic [33:0]         addsub;
    logic                ar_zero;
    logic                ar_borrow;
    logic                ar_carry;
    logic [63:0]         prod;
    logic [63:0]         kn_mask;
    logic [63:0]         result;
    logic [3:0]          res_we;

    // Decimal digit check over the lowest n nibbles
    function automatic logic bcd_valid(input logic [31:0] v, input int n);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < `PAD_DIGITS32; i++) begin
            if (i < n && v[4*i +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // Weighted digit sum, most significant digit first
    function automatic logic [31:0] bcd_value(input logic [31:0] v, input int n);
        logic [31:0] acc;
        acc = 32'h0000_0000;
        for (int i = `PAD_DIGITS32 - 1; i >= 0; i--) begin
            if (i < n) begin
                acc = 32'((acc * 32'h0000_000A) + {28'h000_0000, v[4*i +: 4]});
            end
        end
        return acc;
    endfunction

    // Write strobe aimed at one register
    function automatic logic wr_at(input logic stb, input logic [AW-1:0] a,
                                   input logic [AW-1:0] want);
        return stb && (a == want);
    endfunction

    // Mask of 4*kn low bits for a bit-group destination
    function automatic logic [63:0] nibble_mask(input logic [3:0] kn);
        logic [63:0] m;
        m = 64'h0000_0000_0000_0000;
        for (int i = 0; i < `PAD_DIGITS32; i++) begin
            if (i < int'(kn)) begin
                m[4*i +: 4] = 4'hF;
            end
        end
        return m;
    endfunction

    assign wr_flags  = wr_at(wr_stb, addr, AW'(`PAD_A_FLAGS));
    assign clr_err   = wr_flags && wr_data[`PAD_FL_ERR];
    assign clr_latch = wr_flags && wr_data[`PAD_FL_LATCH];

    // Edge taken between ticks, so slow scans still fire once
    // scan firing
    assign fire = scan_tick && cond_q && (!ctrl_q.pulse || !cond_prev_q);

    assign src1_w = ctrl_q.wide ? {src1_hi_q, src1_lo_q}
                                : {{16{src1_lo_q[15]}}, src1_lo_q};
    assign src2_w = ctrl_q.wide ? {src2_hi_q, src2_lo_q}
                                : {{16{src2_lo_q[15]}}, src2_lo_q};

    always_comb begin
        illegal = 1'b0;
        if (ctrl_q.wide) begin
            if (ctrl_q.idx_f) begin
                illegal = 1'b1;
            end
            if (ctrl_q.op == pad_pkg::PAD_OP_PROD && ctrl_q.idx_e) begin
                illegal = 1'b1;
            end
        end
        if (ctrl_q.op == pad_pkg::PAD_OP_PROD && ctrl_q.dst_bits) begin
            if (ctrl_q.kn < `PAD_KN_MIN) begin
                illegal = 1'b1;
            end
            if (ctrl_q.kn > (ctrl_q.wide ? `PAD_KN_MAX32 : `PAD_KN_MAX16)) begin
                illegal = 1'b1;
            end
        end
    end

    // Refused forms change nothing but the sticky status bit
    assign run = fire && !illegal;

    assign bcd_ok   = bcd_valid(ctrl_q.wide ? {src1_hi_q, src1_lo_q} : {16'h0000, src1_lo_q},
                                ctrl_q.wide ? `PAD_DIGITS32 : `PAD_DIGITS16);
    assign conv_val = bcd_value(ctrl_q.wide ? {src1_hi_q, src1_lo_q} : {16'h0000, src1_lo_q},
                                ctrl_q.wide ? `PAD_DIGITS32 : `PAD_DIGITS16);

    // Two guard bits keep the true result, so range flags need no compare
    // signed sum and difference
    assign addsub = (ctrl_q.op == pad_pkg::PAD_OP_DIFF)
                  ? 34'({{2{src1_w[31]}}, src1_w} - {{2{src2_w[31]}}, src2_w})
                  : 34'({{2{src1_w[31]}}, src1_w} + {{2{src2_w[31]}}, src2_w});

    always_comb begin
        ar_zero   = 1'b0;
        ar_borrow = 1'b0;
        ar_carry  = 1'b0;
        if (ctrl_q.wide) begin
            ar_zero   = (addsub[31:0] == 32'h0000_0000);
            ar_borrow = addsub[33] && !addsub[31];
            ar_carry  = !addsub[33] && addsub[31];
        end else begin
            ar_zero   = (addsub[15:0] == 16'h0000);
            ar_borrow = addsub[16] && !addsub[15];
            ar_carry  = !addsub[16] && addsub[15];
        end
    end

    // One full-width multiplier serves both forms; narrow uses the low words
    // signed double-width product
    assign prod = 64'($signed({{32{src1_w[31]}}, src1_w}) * $signed({{32{src2_w[31]}}, src2_w}));
    assign kn_mask = ctrl_q.dst_bits ? nibble_mask(ctrl_q.kn) : 64'hFFFF_FFFF_FFFF_FFFF;

    always_comb begin
        result = 64'h0000_0000_0000_0000;
        res_we = 4'h0;
        case (ctrl_q.op)
            pad_pkg::PAD_OP_CONV: begin
                result = {32'h0000_0000, conv_val};
                res_we = (!bcd_ok) ? 4'h0 : (ctrl_q.wide ? 4'h3 : 4'h1);
            end
            pad_pkg::PAD_OP_SUM, pad_pkg::PAD_OP_DIFF: begin
                result = 64'(addsub);
                res_we = ctrl_q.wide ? 4'h3 : 4'h1;
            end
            pad_pkg::PAD_OP_PROD: begin
                result = ctrl_q.wide ? (prod & kn_mask) : {32'h0000_0000, prod[31:0] & kn_mask[31:0]};
                res_we = ctrl_q.wide ? 4'hF : 4'h3;
            end
            default: begin
                result = 64'h0000_0000_0000_0000;
                res_we = 4'h0;
            end
        endcase
    end

    // Operand and control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src1_lo_q <= `PAD_RST_WORD;
            src1_hi_q <= `PAD_RST_WORD;
            src2_lo_q <= `PAD_RST_WORD;
            src2_hi_q <= `PAD_RST_WORD;
            ctrl_q    <= pad_pkg::pad_ctrl_t'(11'h000);
            cond_q    <= 1'b0;
        end else if (wr_stb) begin
            case (addr)
                AW'(`PAD_A_SRC1_LO): src1_lo_q <= wr_data;
                AW'(`PAD_A_SRC1_HI): src1_hi_q <= wr_data;
                AW'(`PAD_A_SRC2_LO): src2_lo_q <= wr_data;
                AW'(`PAD_A_SRC2_HI): src2_hi_q <= wr_data;
                AW'(`PAD_A_CTRL):    ctrl_q    <= pad_pkg::pad_ctrl_t'(wr_data[`PAD_CTRL_KN_HI:0]);
                AW'(`PAD_A_COND):    cond_q    <= wr_data[0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cond_prev_q <= 1'b0;
        end else if (scan_tick) begin
            cond_prev_q <= cond_q;
        end
    end

    // Destination words; software may also preload them
    generate
        for (genvar w = 0; w < 4; w++) begin : g_res
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    res_q[w] <= `PAD_RST_WORD;
                end else if (run && res_we[w]) begin
                    res_q[w] <= result[16*w +: 16];
                end else if (wr_at(wr_stb, addr, AW'(32'(`PAD_A_RES0) + w))) begin
                    res_q[w] <= wr_data;
                end
            end
        end
    endgenerate

    // Arithmetic flags, only touched by sum and difference
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_q.zero   <= 1'b0;
            flags_q.borrow <= 1'b0;
            flags_q.carry  <= 1'b0;
        end else if (run && (ctrl_q.op == pad_pkg::PAD_OP_SUM
                          || ctrl_q.op == pad_pkg::PAD_OP_DIFF)) begin
            flags_q.zero   <= ar_zero;
            flags_q.borrow <= ar_borrow;
            flags_q.carry  <= ar_carry;
        end
    end

    // error on bad digit; set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_q.err <= 1'b0;
            err_code_q  <= `PAD_RST_WORD;
        end else if (run && ctrl_q.op == pad_pkg::PAD_OP_CONV && !bcd_ok) begin
            flags_q.err <= 1'b1;
            err_code_q  <= `PAD_ERR_BCD;
        end else begin
            if (clr_err) begin
                flags_q.err <= 1'b0;
            end
            if (wr_at(wr_stb, addr, AW'(`PAD_A_ERRCODE))) begin
                err_code_q <= wr_data;
            end
        end
    end

    // latched error, no clear by later success
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_q.latched <= 1'b0;
        end else if (run && ctrl_q.op == pad_pkg::PAD_OP_CONV && !bcd_ok) begin
            flags_q.latched <= 1'b1;
        end else if (clr_latch) begin
            flags_q.latched <= 1'b0;
        end
    end

    // Refused forms are sticky so software sees them; set wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            illegal_q  <= 1'b0;
            exec_cnt_q <= 8'h00;
        end else begin
            if (fire && illegal) begin
                illegal_q <= 1'b1;
            end else if (wr_at(wr_stb, addr, AW'(`PAD_A_STATUS))
                         && wr_data[`PAD_ST_ILLEGAL]) begin
                illegal_q <= 1'b0;
            end
            if (run) begin
                exec_cnt_q <= 8'(exec_cnt_q + 8'h01);
            end
        end
    end

    // Read port, data valid the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_q <= `PAD_RST_WORD;
        end else if (rd_stb) begin
            case (addr)
                AW'(`PAD_A_SRC1_LO): rd_data_q <= src1_lo_q;
                AW'(`PAD_A_SRC1_HI): rd_data_q <= src1_hi_q;
                AW'(`PAD_A_SRC2_LO): rd_data_q <= src2_lo_q;
                AW'(`PAD_A_SRC2_HI): rd_data_q <= src2_hi_q;
                AW'(`PAD_A_CTRL):    rd_data_q <= {5'h00, ctrl_q};
                AW'(`PAD_A_COND):    rd_data_q <= {15'h0000, cond_q};
                AW'(`PAD_A_RES0):    rd_data_q <= res_q[0];
                AW'(`PAD_A_RES1):    rd_data_q <= res_q[1];
                AW'(`PAD_A_RES2):    rd_data_q <= res_q[2];
                AW'(`PAD_A_RES3):    rd_data_q <= res_q[3];
                AW'(`PAD_A_FLAGS):   rd_data_q <= {11'h000, flags_q};
                AW'(`PAD_A_ERRCODE): rd_data_q <= err_code_q;
                AW'(`PAD_A_STATUS):  rd_data_q <= {exec_cnt_q, 7'h00, illegal_q};
                default:             rd_data_q <= `PAD_RST_WORD;
            endcase
        end else begin
            rd_data_q <= `PAD_RST_WORD;
        end
    end

    assign rd_data                 = rd_data_q;
    assign zero_result_flag        = flags_q.zero;
    assign borrow_out_flag         = flags_q.borrow;
    assign carry_out_flag          = flags_q.carry;
    assign exec_error_flag         = flags_q.err;
    assign exec_error_latched_flag = flags_q.latched;

endmodule
